// ===== logic/sleep_clock_gating_regs.sv
// Sleep and deep-sleep unit clock gating registers with AXI4-Lite access
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
module sleep_clock_gating_regs
    import gating_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] AWADDR,
    input  wire logic        WVALID,
    output logic             WREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    output logic             BVALID,
    input  wire logic        BREADY,
    output logic [1:0]       BRESP,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    input  wire logic [31:0] ARADDR,
    output logic             RVALID,
    input  wire logic        RREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    input  wire logic [1:0]  POWER_MODE,
    input  wire logic        AUTO_GATING_SELECT,
    input  wire logic        RUN_PWM_ENABLE,
    input  wire logic        RUN_WDT_ENABLE,
    input  wire logic        UNIT_ACCESS_VALID,
    input  wire logic        UNIT_ACCESS_UNIT,
    output logic             UNIT_ACCESS_DONE,
    output logic             UNIT_ACCESS_FAULT,
    output logic             PWM_CLOCK_ENABLE,
    output logic             WDT_CLOCK_ENABLE
);
    typedef struct packed {
        logic [31:0] sleep_reg;
        logic [31:0] deep_reg;
        logic        pwm_en;
        logic        wdt_en;
        logic        access_done;
        logic        access_fault;
    } gate_state_t;

    gate_state_t           s;
    gate_state_t           next_s;
    reg_access_if          bus ();
    logic [31:0]           strb_mask;
    logic [31:0]           write_mask;
    logic                  wr_sleep;
    logic                  wr_deep;
    logic                  rd_sleep;
    logic                  rd_deep;
    logic [UNIT_COUNT-1:0] run_enable;
    logic [UNIT_COUNT-1:0] sleep_enable;
    logic [UNIT_COUNT-1:0] deep_enable;
    logic [UNIT_COUNT-1:0] unit_enable;
    logic                  target_on;

    axil_slave_port u_port (
        .clk     (CLK),
        .reset_n (RESET_N),
        .awvalid (AWVALID),
        .awready (AWREADY),
        .awaddr  (AWADDR),
        .wvalid  (WVALID),
        .wready  (WREADY),
        .wdata   (WDATA),
        .wstrb   (WSTRB),
        .bvalid  (BVALID),
        .bready  (BREADY),
        .bresp   (BRESP),
        .arvalid (ARVALID),
        .arready (ARREADY),
        .araddr  (ARADDR),
        .rvalid  (RVALID),
        .rready  (RREADY),
        .rdata   (RDATA),
        .rresp   (RRESP),
        .bus     (bus.initiator)
    );

    // Word decode; low address bits are ignored
    assign wr_sleep = bus.wr_valid && bus.wr_addr[31:2] == SLEEP_ADDR[31:2];
    assign wr_deep  = bus.wr_valid && bus.wr_addr[31:2] == DEEP_ADDR[31:2];
    assign rd_sleep = bus.rd_addr[31:2] == SLEEP_ADDR[31:2];
    assign rd_deep  = bus.rd_addr[31:2] == DEEP_ADDR[31:2];

    // Unmapped addresses answer SLVERR and read as zero
    assign bus.wr_err  = bus.wr_valid && !wr_sleep && !wr_deep;
    assign bus.rd_err  = !rd_sleep && !rd_deep;
    assign bus.rd_data = rd_sleep ? s.sleep_reg
                       : rd_deep  ? s.deep_reg
                       : 32'h00000000;

    // Byte lanes widen to a bit mask
    genvar b;
    generate
        for (b = 0; b < 4; b++)
        begin : g_lane
            assign strb_mask[8*b +: 8] = {8{bus.wr_strb[b]}};
        end
    endgenerate

    // Reserved bits never take write data
    assign write_mask = strb_mask & WRITABLE_MASK;

    assign run_enable   = {RUN_WDT_ENABLE, RUN_PWM_ENABLE};
    assign sleep_enable = {s.sleep_reg[WDT_BIT], s.sleep_reg[PWM_BIT]};
    assign deep_enable  = {s.deep_reg[WDT_BIT], s.deep_reg[PWM_BIT]};

    unit_clock_select u_select (
        .power_mode         (POWER_MODE),
        .auto_gating_select (AUTO_GATING_SELECT),
        .run_enable         (run_enable),
        .sleep_enable       (sleep_enable),
        .deep_enable        (deep_enable),
        .unit_enable        (unit_enable)
    );

    // Access check uses the clock the unit has right now
    assign target_on = (UNIT_ACCESS_UNIT == UNIT_WDT) ? s.wdt_en : s.pwm_en;

    // Register writes, enable selection and unit access answers
    always_comb
    begin
        next_s = s;
        if (wr_sleep)
        begin
            next_s.sleep_reg = (s.sleep_reg & ~write_mask)
                             | (bus.wr_data & write_mask);
            // Reset marker clears on first write, then reads zero
            next_s.sleep_reg[MARKER_BIT] = 1'b0;
        end
        if (wr_deep)
        begin
            next_s.deep_reg = (s.deep_reg & ~write_mask)
                            | (bus.wr_data & write_mask);
            next_s.deep_reg[MARKER_BIT] = 1'b0;
        end
        next_s.pwm_en       = unit_enable[UNIT_PWM];
        next_s.wdt_en       = unit_enable[UNIT_WDT];
        next_s.access_done  = UNIT_ACCESS_VALID && target_on;
        next_s.access_fault = UNIT_ACCESS_VALID && !target_on;
    end

    // Enables start cleared so units sit unclocked until the first edge after reset loads the selected enables
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s           <= '0;
            s.sleep_reg <= GATING_RESET;
            s.deep_reg  <= GATING_RESET;
        end
        else
            s <= next_s;
    end

    assign PWM_CLOCK_ENABLE  = s.pwm_en;
    assign WDT_CLOCK_ENABLE  = s.wdt_en;
    assign UNIT_ACCESS_DONE  = s.access_done;
    assign UNIT_ACCESS_FAULT = s.access_fault;

    // Enable follows the sleep register once the mode has settled
    property p_sleep_pwm_on;
        @(posedge CLK) disable iff (!RESET_N)
        (POWER_MODE == MODE_SLEEP && AUTO_GATING_SELECT
         && s.sleep_reg[PWM_BIT])[*2] |-> PWM_CLOCK_ENABLE;
    endproperty
    a_sleep_pwm_on: assert property (p_sleep_pwm_on)
        else $error("PWM clock off while sleep enable set");

    // PWM access while its clock is off faults on the next cycle
    property p_gated_fault;
        @(posedge CLK) disable iff (!RESET_N)
        UNIT_ACCESS_VALID && UNIT_ACCESS_UNIT == UNIT_PWM && !s.pwm_en
        |=> UNIT_ACCESS_FAULT && !UNIT_ACCESS_DONE;
    endproperty
    a_gated_fault: assert property (p_gated_fault)
        else $error("Access to gated unit did not fault");

    // Deep sleep takes the deep register for the watchdog
    property p_deep_wdt_off;
        @(posedge CLK) disable iff (!RESET_N)
        (POWER_MODE == MODE_DEEP_SLEEP && AUTO_GATING_SELECT
         && !s.deep_reg[WDT_BIT])[*2] |-> !WDT_CLOCK_ENABLE;
    endproperty
    a_deep_wdt_off: assert property (p_deep_wdt_off)
        else $error("Watchdog clocked against deep-sleep register");

    // Without auto gating the run enable rules every mode
    property p_no_auto_run;
        @(posedge CLK) disable iff (!RESET_N)
        !AUTO_GATING_SELECT |=> PWM_CLOCK_ENABLE == $past(RUN_PWM_ENABLE)
                             && WDT_CLOCK_ENABLE == $past(RUN_WDT_ENABLE);
    endproperty
    a_no_auto_run: assert property (p_no_auto_run)
        else $error("Low-power register used without auto gating");

    // Lane-2 write to the sleep register lands in the PWM bit
    property p_pwm_bit_write;
        @(posedge CLK) disable iff (!RESET_N)
        wr_sleep && bus.wr_strb[2]
        |=> s.sleep_reg[PWM_BIT] == $past(bus.wr_data[PWM_BIT])
            && BVALID;
    endproperty
    a_pwm_bit_write: assert property (p_pwm_bit_write)
        else $error("PWM enable bit not written");

    // Watchdog bit of the deep register is writable
    property p_wdt_bit_write;
        @(posedge CLK) disable iff (!RESET_N)
        wr_deep && bus.wr_strb[0]
        |=> s.deep_reg[WDT_BIT] == $past(bus.wr_data[WDT_BIT]);
    endproperty
    a_wdt_bit_write: assert property (p_wdt_bit_write)
        else $error("Watchdog enable bit not written");

    // Reserved bits always read back as zero
    property p_reserved_zero;
        @(posedge CLK) disable iff (!RESET_N)
        RVALID |-> (RDATA & RESERVED_MASK) == 32'h00000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("Reserved bits read nonzero");

    // First edge after release shows the documented reset word
    property p_reset_word;
        @(posedge CLK) disable iff (!RESET_N)
        $rose(RESET_N) |-> s.sleep_reg == GATING_RESET
                        && s.deep_reg == GATING_RESET;
    endproperty
    a_reset_word: assert property (p_reset_word)
        else $error("Gating register reset word wrong");

    // Units start unclocked
    property p_reset_unclocked;
        @(posedge CLK) disable iff (!RESET_N)
        $rose(RESET_N) |-> !PWM_CLOCK_ENABLE && !WDT_CLOCK_ENABLE;
    endproperty
    a_reset_unclocked: assert property (p_reset_unclocked)
        else $error("Unit clocked straight out of reset");

    // Read of the sleep register answers OKAY with its content
    property p_sleep_read;
        @(posedge CLK) disable iff (!RESET_N)
        bus.rd_valid && rd_sleep
        |=> RVALID && RRESP == RESP_OKAY && RDATA == $past(s.sleep_reg);
    endproperty
    a_sleep_read: assert property (p_sleep_read)
        else $error("Sleep register read answer wrong");

    // A low-power write while running leaves run enables in charge
    property p_write_no_effect;
        @(posedge CLK) disable iff (!RESET_N)
        POWER_MODE == MODE_RUN && (wr_sleep || wr_deep)
        |=> PWM_CLOCK_ENABLE == $past(RUN_PWM_ENABLE);
    endproperty
    a_write_no_effect: assert property (p_write_no_effect)
        else $error("Low-power write changed clock in run mode");

    // Watchdog access faults while its clock is off
    property p_gated_wdt_fault;
        @(posedge CLK) disable iff (!RESET_N)
        UNIT_ACCESS_VALID && UNIT_ACCESS_UNIT == UNIT_WDT && !s.wdt_en
        |=> UNIT_ACCESS_FAULT && !UNIT_ACCESS_DONE;
    endproperty
    a_gated_wdt_fault: assert property (p_gated_wdt_fault)
        else $error("Access to gated watchdog did not fault");

    // A clocked unit completes the access normally
    property p_clocked_done;
        @(posedge CLK) disable iff (!RESET_N)
        UNIT_ACCESS_VALID && target_on
        |=> UNIT_ACCESS_DONE && !UNIT_ACCESS_FAULT;
    endproperty
    a_clocked_done: assert property (p_clocked_done)
        else $error("Access to clocked unit did not complete");

    // Sleep register gives the watchdog its clock
    property p_sleep_wdt_on;
        @(posedge CLK) disable iff (!RESET_N)
        (POWER_MODE == MODE_SLEEP && AUTO_GATING_SELECT
         && s.sleep_reg[WDT_BIT])[*2] |-> WDT_CLOCK_ENABLE;
    endproperty
    a_sleep_wdt_on: assert property (p_sleep_wdt_on)
        else $error("Watchdog clock off while sleep enable set");

    // Deep register gates the PWM off
    property p_deep_pwm_off;
        @(posedge CLK) disable iff (!RESET_N)
        (POWER_MODE == MODE_DEEP_SLEEP && AUTO_GATING_SELECT
         && !s.deep_reg[PWM_BIT])[*2] |-> !PWM_CLOCK_ENABLE;
    endproperty
    a_deep_pwm_off: assert property (p_deep_pwm_off)
        else $error("PWM clocked against deep-sleep register");

    // Run and the spare mode code both follow the run enables
    property p_run_mode_run;
        @(posedge CLK) disable iff (!RESET_N)
        POWER_MODE != MODE_SLEEP && POWER_MODE != MODE_DEEP_SLEEP
        |=> PWM_CLOCK_ENABLE == $past(RUN_PWM_ENABLE)
            && WDT_CLOCK_ENABLE == $past(RUN_WDT_ENABLE);
    endproperty
    a_run_mode_run: assert property (p_run_mode_run)
        else $error("Run enables not applied outside low power");

    // Marker bit is gone after any write to its register
    property p_marker_clear;
        @(posedge CLK) disable iff (!RESET_N)
        wr_sleep |=> !s.sleep_reg[MARKER_BIT];
    endproperty
    a_marker_clear: assert property (p_marker_clear)
        else $error("Reset marker survived a write");

    // Unmapped write leaves both registers and answers SLVERR
    property p_unmapped_write;
        @(posedge CLK) disable iff (!RESET_N)
        bus.wr_valid && !wr_sleep && !wr_deep
        |=> $stable(s.sleep_reg) && $stable(s.deep_reg)
            && BVALID && BRESP == RESP_SLVERR;
    endproperty
    a_unmapped_write: assert property (p_unmapped_write)
        else $error("Unmapped write not refused");
endmodule : sleep_clock_gating_regs

// ===== logic/gating_pkg.sv
// Constants and types shared by the low-power clock gating block
package gating_pkg;
    // Register map: system control base plus printed offsets
    localparam logic [31:0] CTRL_BASE        = 32'h400fe000;
    localparam logic [31:0] SLEEP_OFFSET     = 32'h00000110;
    localparam logic [31:0] DEEP_OFFSET      = 32'h00000120;
    localparam logic [31:0] SLEEP_ADDR       = CTRL_BASE + SLEEP_OFFSET;
    localparam logic [31:0] DEEP_ADDR        = CTRL_BASE + DEEP_OFFSET;
    // Field positions and masks
    localparam int          PWM_BIT          = 20;
    localparam int          WDT_BIT          = 3;
    localparam int          MARKER_BIT       = 6;
    localparam logic [31:0] WRITABLE_MASK    = 32'h00100008;
    localparam logic [31:0] RESERVED_MASK    = 32'hffefffb7;
    localparam logic [31:0] GATING_RESET     = 32'h00000040;
    // AXI response codes
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    // Gated units
    localparam int          UNIT_COUNT       = 2;
    localparam logic        UNIT_PWM         = 1'h0;
    localparam logic        UNIT_WDT         = 1'h1;
    // Power mode codes on the mode input
    localparam logic [1:0]  MODE_RUN         = 2'h0;
    localparam logic [1:0]  MODE_SLEEP       = 2'h1;
    localparam logic [1:0]  MODE_DEEP_SLEEP  = 2'h2;
    typedef enum logic [1:0] {
        SRC_RUN,
        SRC_SLEEP,
        SRC_DEEP
    } gate_source_t;
endpackage : gating_pkg

// ===== logic/reg_access_if.sv
// Register access carrier between bus slave and register file
`timescale 1ns/10ps
interface reg_access_if;
    logic        wr_valid;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic        rd_valid;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    logic        rd_err;
    modport initiator (output wr_valid, wr_addr, wr_data, wr_strb,
                       rd_valid, rd_addr,
                       input  wr_err, rd_data, rd_err);
    modport target    (input  wr_valid, wr_addr, wr_data, wr_strb,
                       rd_valid, rd_addr,
                       output wr_err, rd_data, rd_err);
endinterface : reg_access_if

// ===== logic/axil_slave_port.sv
// AXI4-Lite slave front end feeding the register carrier
`timescale 1ns/10ps
module axil_slave_port
    import gating_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [31:0] araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    reg_access_if.initiator  bus
);
    typedef struct packed {
        logic        aw_held;
        logic [31:0] aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        b_valid;
        logic [1:0]  b_resp;
        logic        ar_held;
        logic [31:0] ar_addr;
        logic        r_valid;
        logic [31:0] r_data;
        logic [1:0]  r_resp;
    } port_state_t;

    port_state_t s;
    port_state_t next_s;

    // Up to two writes (one awaiting its response) and one read in flight; response held until taken
    always_comb
    begin
        next_s = s;
        if (awvalid && !s.aw_held)
        begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && !s.w_held)
        begin
            next_s.w_held = 1'b1;
            next_s.w_data = wdata;
            next_s.w_strb = wstrb;
        end
        if (s.b_valid && bready)
            next_s.b_valid = 1'b0;
        if (bus.wr_valid)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.b_valid = 1'b1;
            next_s.b_resp  = bus.wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (arvalid && !s.ar_held && !s.r_valid)
        begin
            next_s.ar_held = 1'b1;
            next_s.ar_addr = araddr;
        end
        if (s.r_valid && rready)
            next_s.r_valid = 1'b0;
        if (bus.rd_valid)
        begin
            next_s.ar_held = 1'b0;
            next_s.r_valid = 1'b1;
            next_s.r_data  = bus.rd_data;
            next_s.r_resp  = bus.rd_err ? RESP_SLVERR : RESP_OKAY;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            s <= '0;
        else
            s <= next_s;
    end

    // Ready flags are plain state, so no path runs valid to ready
    assign awready      = !s.aw_held;
    assign wready       = !s.w_held;
    assign arready      = !s.ar_held && !s.r_valid;
    assign bvalid       = s.b_valid;
    assign bresp        = s.b_resp;
    assign rvalid       = s.r_valid;
    assign rdata        = s.r_data;
    assign rresp        = s.r_resp;
    assign bus.wr_valid = s.aw_held && s.w_held && !s.b_valid;
    assign bus.wr_addr  = s.aw_addr;
    assign bus.wr_data  = s.w_data;
    assign bus.wr_strb  = s.w_strb;
    assign bus.rd_valid = s.ar_held && !s.r_valid;
    assign bus.rd_addr  = s.ar_addr;
endmodule : axil_slave_port

// ===== logic/unit_clock_select.sv
// Picks each unit's clock enable from the run enable or from the low-power register of the power mode
`timescale 1ns/10ps
module unit_clock_select
    import gating_pkg::*;
(
    input  wire logic [1:0]            power_mode,
    input  wire logic                  auto_gating_select,
    input  wire logic [UNIT_COUNT-1:0] run_enable,
    input  wire logic [UNIT_COUNT-1:0] sleep_enable,
    input  wire logic [UNIT_COUNT-1:0] deep_enable,
    output logic      [UNIT_COUNT-1:0] unit_enable
);
    gate_source_t source;

    // Low-power registers only count when auto gating is selected
    always_comb
    begin
        source = SRC_RUN;
        if (auto_gating_select && power_mode == MODE_SLEEP)
            source = SRC_SLEEP;
        else if (auto_gating_select && power_mode == MODE_DEEP_SLEEP)
            source = SRC_DEEP;
    end

    genvar u;
    generate
        for (u = 0; u < UNIT_COUNT; u++)
        begin : g_unit
            assign unit_enable[u] = (source == SRC_SLEEP) ? sleep_enable[u]
                                  : (source == SRC_DEEP)  ? deep_enable[u]
                                  : run_enable[u];
        end
    endgenerate
endmodule : unit_clock_select

// ===== tb/test_sleep_clock_gating_regs.sv
// Self-checking bench for the low-power clock gating registers
`timescale 1ns/10ps
module test_sleep_clock_gating_regs
    import gating_pkg::*;
    ();
    localparam int LIMIT = 2000;
    logic        CLK;
    logic        RESET_N;
    logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic        ARVALID, ARREADY, RVALID, RREADY;
    logic [31:0] AWADDR, WDATA, ARADDR, RDATA;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP, POWER_MODE;
    logic        AUTO_GATING_SELECT, RUN_PWM_ENABLE, RUN_WDT_ENABLE;
    logic        UNIT_ACCESS_VALID, UNIT_ACCESS_UNIT;
    logic        UNIT_ACCESS_DONE, UNIT_ACCESS_FAULT;
    logic        PWM_CLOCK_ENABLE, WDT_CLOCK_ENABLE;
    int          n_fail;
    int          n_tests;
    int          cycles = 0;
    // Mode table: run, sleep, deep, no auto twice, illegal code 3
    logic [1:0]  mode_tab [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h3};
    logic [5:0]  auto_tab = 6'b100111;
    logic [5:0]  pwm_tab  = 6'b111011;
    logic [5:0]  wdt_tab  = 6'b000110;

    sleep_clock_gating_regs sleep_clock_gating_regs_i (
        .CLK (CLK), .RESET_N (RESET_N),
        .AWVALID (AWVALID), .AWREADY (AWREADY), .AWADDR (AWADDR),
        .WVALID (WVALID), .WREADY (WREADY), .WDATA (WDATA),
        .WSTRB (WSTRB), .BVALID (BVALID), .BREADY (BREADY),
        .BRESP (BRESP), .ARVALID (ARVALID), .ARREADY (ARREADY),
        .ARADDR (ARADDR), .RVALID (RVALID), .RREADY (RREADY),
        .RDATA (RDATA), .RRESP (RRESP), .POWER_MODE (POWER_MODE),
        .AUTO_GATING_SELECT (AUTO_GATING_SELECT),
        .RUN_PWM_ENABLE (RUN_PWM_ENABLE),
        .RUN_WDT_ENABLE (RUN_WDT_ENABLE),
        .UNIT_ACCESS_VALID (UNIT_ACCESS_VALID),
        .UNIT_ACCESS_UNIT (UNIT_ACCESS_UNIT),
        .UNIT_ACCESS_DONE (UNIT_ACCESS_DONE),
        .UNIT_ACCESS_FAULT (UNIT_ACCESS_FAULT),
        .PWM_CLOCK_ENABLE (PWM_CLOCK_ENABLE),
        .WDT_CLOCK_ENABLE (WDT_CLOCK_ENABLE)
    );

    // 250 MHz clock
    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    // Verdict and end of run
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // Compare tasks, one per result width
    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_data

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_resp

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    // Write: each channel dropped only at the edge its ready is seen
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge CLK);
            if (AWREADY === 1'b1)
                AWVALID <= 1'b0;
            if (WREADY === 1'b1)
                WVALID <= 1'b0;
            aw_ok = aw_ok || (AWREADY === 1'b1);
            w_ok = w_ok || (WREADY === 1'b1);
        end
        do
            @(posedge CLK);
        while (BVALID !== 1'b1);
        r = BRESP;
        BREADY <= 1'b0;
    endtask : axi_write

    // Read: data and response taken at the edge RVALID is seen
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do
            @(posedge CLK);
        while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do
            @(posedge CLK);
        while (RVALID !== 1'b1);
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
    endtask : axi_read

    // Read and compare both data and response
    task automatic read_chk(input logic [31:0] a, input logic [31:0] exp,
                            input logic [1:0] exp_r);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        chk_data(d, exp);
        chk_resp(r, exp_r);
    endtask : read_chk

    // One unit access; the answer is a pulse one edge later
    task automatic unit_access(input logic u, input logic fault);
        UNIT_ACCESS_VALID <= 1'b1;
        UNIT_ACCESS_UNIT <= u;
        @(posedge CLK);
        UNIT_ACCESS_VALID <= 1'b0;
        #1;
        chk_bit(UNIT_ACCESS_FAULT, fault);
        chk_bit(UNIT_ACCESS_DONE, !fault);
        @(posedge CLK);
    endtask : unit_access

    // Hang guard; the whole run needs under a hundred cycles
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            n_fail++;
            end_sim();
        end
    end

    // Main sequence
    initial
    begin
        logic [1:0] r;
        n_fail = 0;
        n_tests = 0;
        RESET_N = 1'b0;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
        {AWADDR, WDATA, ARADDR} = {32'h0, 32'h0, 32'h0};
        WSTRB = 4'h0;
        POWER_MODE = MODE_RUN;
        {AUTO_GATING_SELECT, RUN_PWM_ENABLE, RUN_WDT_ENABLE} = 3'h0;
        {UNIT_ACCESS_VALID, UNIT_ACCESS_UNIT} = 2'h0;
        repeat (10) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        // Reset values of both registers
        read_chk(SLEEP_ADDR, 32'h00000040, RESP_OKAY);
        read_chk(DEEP_ADDR, 32'h00000040, RESP_OKAY);
        chk_bit(PWM_CLOCK_ENABLE, 1'b0);
        chk_bit(WDT_CLOCK_ENABLE, 1'b0);
        $display("Test reset_values finished");
        // All ones: only enables stick, marker bit drops
        axi_write(SLEEP_ADDR, 32'hffffffff, 4'hf, r);
        chk_resp(r, RESP_OKAY);
        read_chk(SLEEP_ADDR, 32'h00100008, RESP_OKAY);
        read_chk(DEEP_ADDR, 32'h00000040, RESP_OKAY);
        axi_write(DEEP_ADDR, 32'hffeffff7 | 32'h8, 4'hf, r);
        chk_resp(r, RESP_OKAY);
        read_chk(DEEP_ADDR, 32'h00000008, RESP_OKAY);
        $display("Test field_access finished");
        // Unmapped word beside the sleep register
        axi_write(SLEEP_ADDR + 32'h4, 32'h00100008, 4'hf, r);
        chk_resp(r, RESP_SLVERR);
        read_chk(SLEEP_ADDR + 32'h4, 32'h0, RESP_SLVERR);
        read_chk(SLEEP_ADDR, 32'h00100008, RESP_OKAY);
        $display("Test unmapped finished");
        // Watchdog run enable differs from both stored registers, PWM run enable from the deep one
        RUN_PWM_ENABLE <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            POWER_MODE <= mode_tab[i];
            AUTO_GATING_SELECT <= auto_tab[i];
            @(posedge CLK);
            #1;
            chk_bit(PWM_CLOCK_ENABLE, pwm_tab[i]);
            chk_bit(WDT_CLOCK_ENABLE, wdt_tab[i]);
            @(posedge CLK);
        end
        $display("Test mode_select finished");
        // Deep sleep: PWM gated off, watchdog clocked
        POWER_MODE <= MODE_DEEP_SLEEP;
        AUTO_GATING_SELECT <= 1'b1;
        repeat (2) @(posedge CLK);
        unit_access(UNIT_PWM, 1'b1);
        unit_access(UNIT_WDT, 1'b0);
        POWER_MODE <= MODE_SLEEP;
        repeat (2) @(posedge CLK);
        unit_access(UNIT_PWM, 1'b0);
        $display("Test unit_access finished");
        // Byte lane 2 only: clears PWM, keeps watchdog
        axi_write(SLEEP_ADDR, 32'h0, 4'h4, r);
        chk_resp(r, RESP_OKAY);
        read_chk(SLEEP_ADDR, 32'h00000008, RESP_OKAY);
        @(posedge CLK);
        #1;
        chk_bit(PWM_CLOCK_ENABLE, 1'b0);
        @(posedge CLK);
        $display("Test byte_strobe finished");
        // Deep register cleared in deep sleep: watchdog gated
        POWER_MODE <= MODE_DEEP_SLEEP;
        axi_write(DEEP_ADDR, 32'h0, 4'hf, r);
        chk_resp(r, RESP_OKAY);
        repeat (2) @(posedge CLK);
        unit_access(UNIT_WDT, 1'b1);
        chk_bit(WDT_CLOCK_ENABLE, 1'b0);
        $display("Test deep_gating finished");
        // Second reset in mid-run restores the marker value
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        read_chk(SLEEP_ADDR, 32'h00000040, RESP_OKAY);
        read_chk(DEEP_ADDR, 32'h00000040, RESP_OKAY);
        $display("Test second_reset finished");
        end_sim();
    end
endmodule : test_sleep_clock_gating_regs
